// file: hw/pta_defines.svh
// register offsets, field positions, reset values and codes of the position tracker
`ifndef PTA_DEFINES_SVH
`define PTA_DEFINES_SVH
`define PTA_OFF_ENC_TYPE 8'h00
`define PTA_OFF_MODE 8'h04
`define PTA_OFF_CTRL 8'h08
`define PTA_OFF_STAT 8'h0c
`define PTA_OFF_MASK 8'h10
`define PTA_OFF_SINGLE 8'h14
`define PTA_OFF_TURNS 8'h18
`define PTA_OFF_ZERO_LO 8'h1c
`define PTA_OFF_ZERO_HI 8'h20
`define PTA_OFF_MECH_LO 8'h24
`define PTA_OFF_MECH_HI 8'h28
`define PTA_OFF_HOME_ST 8'h2c
`define PTA_OFF_TARGET 8'h30
`define PTA_OFF_TGT_ENC 8'h34
`define PTA_CTRL_HOME 0
`define PTA_CTRL_FCLR 1
`define PTA_ST_OVF 0
`define PTA_ST_BLOST 1
`define PTA_ST_BLOW 2
`define PTA_ENC_TYPE_RST 16'h0000
`define PTA_MODE_RST 1'b0
`define PTA_TYPE_24BIT 16'h0002
`define PTA_TURN_LIMIT 16'h8000
`define PTA_RES_LO 17
`define PTA_RES_HI 24
`define PTA_RESP_OKAY 2'b00
`define PTA_RESP_SLVERR 2'b10
`endif

// file: hw/pta_pkg.sv
// types of the absolute encoder position tracker
package pta_pkg;
  typedef logic [47:0] pta_pos_t;
  typedef enum logic [0:0] {
    PTA_MODE_INCR = 1'b0,
    PTA_MODE_ABS = 1'b1
  } pta_mode_e;
  typedef struct packed {
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] enc_type;
    pta_mode_e mode;
    logic [2:0] stat;
    logic [2:0] mask;
    logic [23:0] single;
    logic [15:0] raw_turns;
    logic [15:0] turn_base;
    logic base_taken;
    pta_pos_t zero_base;
    pta_pos_t zero_off;
    pta_pos_t mech;
    logic homed;
    logic [31:0] target;
    pta_pos_t tgt_enc;
    logic [2:0] bok_sync;
    logic [2:0] blow_sync;
    logic bok_lvl;
    logic blow_lvl;
  } pta_state_s;
endpackage : pta_pkg

// file: hw/pta_tracker.sv
// absolute encoder position tracker with axi4-lite register slave
//
// Summary of operation
// - keep signed 16-bit revolution count
// - single-turn resolution 17 or 24 bits
// - mode register picks incremental or absolute use
// - incremental use: no turn retention, home each power-up
// - absolute use: turns retained, one homing suffices
// - absolute use: beyond 32767 turns raises overflow
// - absolute use: first battery power reports battery lost
// - homing records zero offset, mech = enc - offset
// - incremental encoder homing clears encoder position
// - position targets are mechanical user units
// - low battery voltage reports battery low fault
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "pta_defines.svh"

module pta_tracker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic enc_valid,
  input wire logic [23:0] enc_single_turn,
  input wire logic [15:0] enc_multi_turn,
  input wire logic batt_ok_pin,
  input wire logic batt_low_pin,
  output logic [47:0] mech_pos,
  output logic [47:0] target_enc_pos,
  output logic homing_required,
  output logic irq
);

  pta_pkg::pta_state_s q, d;

  // byte-lane merge of a write into a register word
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : lane_merge

  // turns and angle joined into one position count
  function automatic pta_pkg::pta_pos_t join_pos(input logic [15:0] turns,
                                                  input logic [23:0] angle,
                                                  input logic res24);
    pta_pkg::pta_pos_t t;
    t = {{32{turns[15]}}, turns};
    if (res24) begin
      return (t <<< `PTA_RES_HI) + {24'h000000, angle};
    end
    return (t <<< `PTA_RES_LO) + {31'h00000000, angle[16:0]};
  endfunction : join_pos

  // incremental types are the abz, line-saving and rotary-to-incremental codes
  function automatic logic is_incr_type(input logic [15:0] t);
    return (t == 16'h0000) || (t == 16'h0004) || (t == 16'h0005) || (t == 16'h0009);
  endfunction : is_incr_type

  logic res24;
  logic [15:0] turns;
  pta_pkg::pta_pos_t raw_pos, enc_pos;
  logic wr_go, home_cmd, fclr_cmd, bok_rise;
  logic [2:0] ev;
  logic [31:0] wmerged;

  assign res24 = (q.enc_type == `PTA_TYPE_24BIT);
  // incremental use counts turns only from the first sample after reset
  assign turns = (q.mode == pta_pkg::PTA_MODE_ABS) ? q.raw_turns
                                                   : q.raw_turns - q.turn_base;
  assign raw_pos = join_pos(turns, q.single, res24);
  assign enc_pos = raw_pos - q.zero_base;
  assign wr_go = q.aw_held && q.w_held && !q.bvalid;
  assign wmerged = lane_merge(32'h00000000, q.wdata, q.wstrb);
  assign home_cmd = wr_go && (q.awaddr == `PTA_OFF_CTRL) && wmerged[`PTA_CTRL_HOME];
  assign fclr_cmd = wr_go && (q.awaddr == `PTA_OFF_CTRL) && wmerged[`PTA_CTRL_FCLR];
  // second and third stage agree before a battery change counts
  assign bok_rise = (q.bok_sync[1] == q.bok_sync[2]) && q.bok_sync[2] && !q.bok_lvl;

  always_comb begin
    ev = 3'h0;
    if (q.mode == pta_pkg::PTA_MODE_ABS) begin
      ev[`PTA_ST_OVF] = enc_valid && (enc_multi_turn == `PTA_TURN_LIMIT);
      ev[`PTA_ST_BLOST] = bok_rise;
    end
    ev[`PTA_ST_BLOW] = q.blow_lvl;
  end

  always_comb begin
    d = q;
    d.bok_sync = {q.bok_sync[1:0], batt_ok_pin};
    d.blow_sync = {q.blow_sync[1:0], batt_low_pin};
    if (q.bok_sync[1] == q.bok_sync[2]) begin
      d.bok_lvl = q.bok_sync[2];
    end
    if (q.blow_sync[1] == q.blow_sync[2]) begin
      d.blow_lvl = q.blow_sync[2];
    end
    if (enc_valid) begin
      d.single = enc_single_turn;
      d.raw_turns = enc_multi_turn;
      if (!q.base_taken) begin
        d.turn_base = enc_multi_turn;
        d.base_taken = 1'b1;
      end
    end
    // axi write address and data are taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_held = 1'b1;
      d.awaddr = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_held = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (wr_go) begin
      d.aw_held = 1'b0;
      d.w_held = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = `PTA_RESP_OKAY;
      unique case (q.awaddr)
        `PTA_OFF_ENC_TYPE: begin
          d.enc_type = 16'(lane_merge({16'h0000, q.enc_type}, q.wdata, q.wstrb));
        end
        `PTA_OFF_MODE: begin
          if (q.wstrb[0]) begin
            d.mode = pta_pkg::pta_mode_e'(q.wdata[0]);
          end
        end
        `PTA_OFF_CTRL: begin
        end
        `PTA_OFF_STAT: begin
          d.stat = q.stat & ~wmerged[2:0];
        end
        `PTA_OFF_MASK: begin
          d.mask = 3'(lane_merge({29'h0, q.mask}, q.wdata, q.wstrb));
        end
        // software restores a saved offset in absolute use after power-up
        `PTA_OFF_ZERO_LO: begin
          d.zero_off[31:0] = lane_merge(q.zero_off[31:0], q.wdata, q.wstrb);
        end
        `PTA_OFF_ZERO_HI: begin
          d.zero_off[47:32] = 16'(lane_merge({16'h0, q.zero_off[47:32]}, q.wdata, q.wstrb));
          d.homed = 1'b1;
        end
        `PTA_OFF_TARGET: begin
          d.target = lane_merge(q.target, q.wdata, q.wstrb);
        end
        `PTA_OFF_SINGLE, `PTA_OFF_TURNS, `PTA_OFF_MECH_LO, `PTA_OFF_MECH_HI,
        `PTA_OFF_HOME_ST, `PTA_OFF_TGT_ENC: begin
        end
        default: begin
          d.bresp = `PTA_RESP_SLVERR;
        end
      endcase
    end
    if (home_cmd) begin
      d.homed = 1'b1;
      if (is_incr_type(q.enc_type)) begin
        d.zero_base = raw_pos;
        d.zero_off = 48'h000000000000;
      end else begin
        d.zero_off = enc_pos;
      end
    end
    if (fclr_cmd) begin
      d.stat = 3'h0;
    end
    // a fault arriving with its clear stays set
    d.stat = d.stat | ev;
    d.mech = enc_pos - q.zero_off;
    d.tgt_enc = {{16{q.target[31]}}, q.target} + q.zero_off + q.zero_base;
    if (s_axi_arvalid && s_axi_arready) begin
      d.rvalid = 1'b1;
      d.rresp = `PTA_RESP_OKAY;
      unique case ({s_axi_araddr[7:2], 2'b00})
        `PTA_OFF_ENC_TYPE: d.rdata = {16'h0000, q.enc_type};
        `PTA_OFF_MODE: d.rdata = {31'h0, q.mode};
        `PTA_OFF_CTRL: d.rdata = 32'h00000000;
        `PTA_OFF_STAT: d.rdata = {29'h0, q.stat};
        `PTA_OFF_MASK: d.rdata = {29'h0, q.mask};
        `PTA_OFF_SINGLE: d.rdata = res24 ? {8'h00, q.single} : {15'h0000, q.single[16:0]};
        `PTA_OFF_TURNS: d.rdata = {{16{turns[15]}}, turns};
        `PTA_OFF_ZERO_LO: d.rdata = q.zero_off[31:0];
        `PTA_OFF_ZERO_HI: d.rdata = {{16{q.zero_off[47]}}, q.zero_off[47:32]};
        `PTA_OFF_MECH_LO: d.rdata = q.mech[31:0];
        `PTA_OFF_MECH_HI: d.rdata = {{16{q.mech[47]}}, q.mech[47:32]};
        `PTA_OFF_HOME_ST: d.rdata = {30'h0, homing_required, q.homed};
        `PTA_OFF_TARGET: d.rdata = q.target;
        `PTA_OFF_TGT_ENC: d.rdata = q.tgt_enc[31:0];
        default: begin
          d.rdata = 32'h00000000;
          d.rresp = `PTA_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.enc_type <= `PTA_ENC_TYPE_RST;
      q.mode <= pta_pkg::pta_mode_e'(`PTA_MODE_RST);
    end else begin
      q <= d;
    end
  end

  // a single outstanding response each way keeps ordering trivial
  assign s_axi_awready = !q.aw_held && !q.bvalid;
  assign s_axi_wready = !q.w_held && !q.bvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign mech_pos = q.mech;
  assign target_enc_pos = q.tgt_enc;
  // absolute use loses its homing only when the battery was lost
  assign homing_required = (q.mode == pta_pkg::PTA_MODE_INCR) ? !q.homed
                           : (!q.homed || q.stat[`PTA_ST_BLOST]);
  assign irq = |(q.stat & q.mask);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_home;
    home_cmd;
  endsequence
  sequence s_mech_follows;
    ##1 (q.mech == $past(enc_pos) - $past(q.zero_off));
  endsequence

  chk_turn_overflow: assert property (
    (q.mode == pta_pkg::PTA_MODE_ABS && enc_valid && enc_multi_turn == 16'h8000)
      |=> q.stat[0])
    else $error("overflow fault not raised");
  chk_no_ovf_incr: assert property (
    (q.mode == pta_pkg::PTA_MODE_INCR && $past(q.mode) == pta_pkg::PTA_MODE_INCR &&
     !$past(q.stat[0])) |-> !q.stat[0])
    else $error("overflow raised in incremental use");
  chk_batt_lost: assert property (
    (q.mode == pta_pkg::PTA_MODE_ABS && bok_rise) |=> q.stat[1])
    else $error("battery lost fault not raised");
  chk_batt_low: assert property (
    q.blow_lvl |=> q.stat[2])
    else $error("battery low fault not raised");
  chk_fault_latch: assert property (
    (q.stat[2] && !fclr_cmd && !(wr_go && q.awaddr == 8'h0c)) |=> q.stat[2])
    else $error("fault dropped without clear");
  chk_mech_offset: assert property (
    s_home ##0 (!is_incr_type(q.enc_type)) |=> (q.zero_off == $past(enc_pos)))
    else $error("zero offset not recorded");
  chk_incr_home: assert property (
    s_home ##0 is_incr_type(q.enc_type) |=> ##1 (q.mech == 48'h0 || $past(enc_valid, 2)))
    else $error("incremental homing did not clear position");
  chk_mech_calc: assert property (
    1'b1 |-> s_mech_follows)
    else $error("mechanical position wrong");
  chk_homing_need: assert property (
    (q.mode == pta_pkg::PTA_MODE_INCR && !q.homed) |-> homing_required)
    else $error("homing not demanded");
  chk_target_map: assert property (
    ##1 (q.tgt_enc == {{16{$past(q.target[31])}}, $past(q.target)} + $past(q.zero_off)
         + $past(q.zero_base)))
    else $error("target not mapped from mechanical units");
  chk_resolution: assert property (
    (!res24 && s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h14)
      |=> (s_axi_rdata[31:17] == 15'h0))
    else $error("single turn exceeds 17 bits");

  sequence s_wr_taken;
    wr_go;
  endsequence
  sequence s_bus_answer;
    ##1 s_axi_bvalid;
  endsequence
  // a mode write in the same cycle moves the count back to raw turns
  sequence s_first_incr_sample;
    q.mode == pta_pkg::PTA_MODE_INCR && enc_valid && !q.base_taken;
  endsequence

  chk_home_marks: assert property (
    s_home |=> q.homed)
    else $error("homing not recorded");
  chk_incr_base: assert property (
    s_first_incr_sample |=> (q.mode == pta_pkg::PTA_MODE_ABS || turns == 16'h0000))
    else $error("incremental turn count not zeroed");
  chk_set_wins: assert property (
    (fclr_cmd && ev != 3'h0) |=> ((q.stat & $past(ev)) == $past(ev)))
    else $error("fault lost to a clear");
  chk_ovf_latch: assert property (
    (q.stat[`PTA_ST_OVF] && !fclr_cmd && !(wr_go && q.awaddr == `PTA_OFF_STAT))
      |=> q.stat[`PTA_ST_OVF])
    else $error("overflow fault dropped without clear");
  chk_lost_latch: assert property (
    (q.stat[`PTA_ST_BLOST] && !fclr_cmd && !(wr_go && q.awaddr == `PTA_OFF_STAT))
      |=> q.stat[`PTA_ST_BLOST])
    else $error("battery lost fault dropped without clear");
  chk_wr_answer: assert property (
    s_wr_taken |-> s_bus_answer)
    else $error("write not answered");
  chk_b_hold: assert property (
    (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write response not held");
  chk_r_hold: assert property (
    (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
    else $error("read data not held");
  chk_rd_answer: assert property (
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read not answered");
  chk_mode_write: assert property (
    (wr_go && q.awaddr == `PTA_OFF_MODE && q.wstrb[0])
      |=> (1'(q.mode) == $past(q.wdata[0])))
    else $error("mode select not written");
  chk_res24_read: assert property (
    (res24 && s_axi_arvalid && s_axi_arready && s_axi_araddr == `PTA_OFF_SINGLE)
      |=> (s_axi_rdata[31:24] == 8'h00))
    else $error("single turn exceeds 24 bits");

endmodule : pta_tracker

// file: tb/pta_enc_model.sv
// encoder and backup battery model for the position tracker
`timescale 1ns/10ps
module pta_enc_model (
  input wire logic aclk,
  output logic enc_valid,
  output logic [23:0] enc_single_turn,
  output logic [15:0] enc_multi_turn,
  output logic batt_ok_pin,
  output logic batt_low_pin
);
  initial begin
    enc_valid = 1'b0;
    enc_single_turn = 24'h000000;
    enc_multi_turn = 16'h0000;
    batt_ok_pin = 1'b0;
    batt_low_pin = 1'b0;
  end
  // one sample per pulse; data lines carry junk between pulses
  task automatic send(input logic [23:0] s, input logic [15:0] m);
    @(posedge aclk);
    enc_valid <= 1'b1;
    enc_single_turn <= s;
    enc_multi_turn <= m;
    @(posedge aclk);
    enc_valid <= 1'b0;
    enc_single_turn <= ~s;
    enc_multi_turn <= ~m;
    repeat (3) @(posedge aclk);
  endtask : send
  // slow levels; wait out the sync chain
  task automatic batt(input logic ok, input logic low);
    @(posedge aclk);
    batt_ok_pin <= ok;
    batt_low_pin <= low;
    repeat (8) @(posedge aclk);
  endtask : batt
endmodule : pta_enc_model

// file: tb/tb_pta_tracker.sv
// self-checking bench of the position tracker
`timescale 1ns/10ps
`include "pta_defines.svh"
module tb_pta_tracker;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, homing_required, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [47:0] mech_pos, target_enc_pos;
  logic enc_valid, batt_ok_pin, batt_low_pin;
  logic [23:0] enc_single_turn;
  logic [15:0] enc_multi_turn;
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  always #50 aclk = ~aclk;
  pta_tracker DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .enc_valid(enc_valid),
    .enc_single_turn(enc_single_turn), .enc_multi_turn(enc_multi_turn),
    .batt_ok_pin(batt_ok_pin), .batt_low_pin(batt_low_pin), .mech_pos(mech_pos),
    .target_enc_pos(target_enc_pos), .homing_required(homing_required), .irq(irq));
  pta_enc_model enc_mdl (.aclk(aclk), .enc_valid(enc_valid),
    .enc_single_turn(enc_single_turn), .enc_multi_turn(enc_multi_turn),
    .batt_ok_pin(batt_ok_pin), .batt_low_pin(batt_low_pin));
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk1(input logic got, input logic exp);
    chk({47'h0, got}, {47'h0, exp});
  endtask : chk1
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    chk({46'h0, bresp}, {46'h0, er});
    bready <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic ar;
    ar = 1'b1;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (ar) begin
      @(posedge aclk);
      if (arready) begin
        ar = 1'b0;
        arvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (rvalid !== 1'b1);
    chk({16'h0, rdata}, {16'h0, e});
    rready <= 1'b0;
  endtask : rchk
  task automatic t_reset();
    chk1(homing_required, 1'b1);
    chk1(irq, 1'b0);
    rchk(`PTA_OFF_ENC_TYPE, 32'h0);
    rchk(`PTA_OFF_MODE, 32'h0);
    rchk(`PTA_OFF_STAT, 32'h0);
    rchk(`PTA_OFF_MASK, 32'h0);
    wr(8'h3c, 32'h1, 2'b10);
  endtask : t_reset
  // incremental use ignores battery loss; only a low battery is still reported
  task automatic t_incr();
    enc_mdl.batt(1'b1, 1'b0);
    rchk(`PTA_OFF_STAT, 32'h0);
    chk1(homing_required, 1'b1);
    enc_mdl.batt(1'b0, 1'b0);
    wr(`PTA_OFF_CTRL, 32'h1);
    chk1(homing_required, 1'b0);
  endtask : t_incr
  task automatic t_res();
    wr(`PTA_OFF_ENC_TYPE, 32'h2);
    enc_mdl.send(24'habcdef, 16'h0001);
    rchk(`PTA_OFF_SINGLE, 32'h00abcdef);
    wr(`PTA_OFF_ENC_TYPE, 32'h1);
    rchk(`PTA_OFF_ENC_TYPE, 32'h1);
    enc_mdl.send(24'habcdef, 16'h0001);
    rchk(`PTA_OFF_SINGLE, 32'h0001cdef);
  endtask : t_res
  task automatic t_abs();
    wr(`PTA_OFF_MODE, 32'h1);
    rchk(`PTA_OFF_MODE, 32'h1);
    wr(`PTA_OFF_MASK, 32'h2);
    enc_mdl.batt(1'b1, 1'b0);
    rchk(`PTA_OFF_STAT, 32'h2);
    chk1(irq, 1'b1);
    chk1(homing_required, 1'b1);
    wr(`PTA_OFF_STAT, 32'h2);
    rchk(`PTA_OFF_STAT, 32'h0);
    chk1(irq, 1'b0);
    enc_mdl.send(24'h000064, 16'h0003);
    wr(`PTA_OFF_CTRL, 32'h1);
    rchk(`PTA_OFF_ZERO_LO, 32'h00060064);
    chk(mech_pos, 48'h0);
    chk1(homing_required, 1'b0);
    enc_mdl.send(24'h000096, 16'h0004);
    chk(mech_pos, 48'h020032);
    enc_mdl.send(24'h000064, 16'hffff);
    chk(mech_pos, 48'hfffffff80000);
    rchk(`PTA_OFF_TURNS, 32'hffffffff);
    wr(`PTA_OFF_TARGET, 32'hfffffffb);
    repeat (3) @(posedge aclk);
    chk(target_enc_pos, 48'h06005f);
  endtask : t_abs
  // edge of the turn range, then a clear by control
  task automatic t_ovf();
    wr(`PTA_OFF_MASK, 32'h1);
    enc_mdl.send(24'h0, 16'h7fff);
    rchk(`PTA_OFF_STAT, 32'h0);
    enc_mdl.send(24'h0, 16'h8000);
    rchk(`PTA_OFF_STAT, 32'h1);
    chk1(irq, 1'b1);
    enc_mdl.send(24'h0, 16'h0001);
    rchk(`PTA_OFF_STAT, 32'h1);
    wr(`PTA_OFF_CTRL, 32'h2);
    rchk(`PTA_OFF_STAT, 32'h0);
    chk1(irq, 1'b0);
  endtask : t_ovf
  task automatic t_low();
    wr(`PTA_OFF_MASK, 32'h4);
    enc_mdl.batt(1'b1, 1'b1);
    rchk(`PTA_OFF_STAT, 32'h4);
    chk1(irq, 1'b1);
    // clear while the low-battery pin is still set: the set must win
    wr(`PTA_OFF_CTRL, 32'h2);
    rchk(`PTA_OFF_STAT, 32'h4);
    enc_mdl.batt(1'b1, 1'b0);
    rchk(`PTA_OFF_STAT, 32'h4);
    wr(`PTA_OFF_STAT, 32'h4);
    rchk(`PTA_OFF_STAT, 32'h0);
  endtask : t_low
  task automatic t_incenc();
    wr(`PTA_OFF_ENC_TYPE, 32'h0);
    enc_mdl.send(24'h000064, 16'h0003);
    wr(`PTA_OFF_CTRL, 32'h1);
    rchk(`PTA_OFF_ZERO_LO, 32'h0);
    enc_mdl.send(24'h00006e, 16'h0003);
    chk(mech_pos, 48'h00000a);
  endtask : t_incenc
  // a second power-up must demand homing again
  task automatic t_rst2();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk1(homing_required, 1'b1);
    rchk(`PTA_OFF_MODE, 32'h0);
    rchk(`PTA_OFF_ZERO_LO, 32'h0);
    rchk(`PTA_OFF_STAT, 32'h0);
  endtask : t_rst2
  // hang guard; a full run needs a few hundred cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_incr();
    t_res();
    t_abs();
    t_ovf();
    t_low();
    t_incenc();
    t_rst2();
    give_verdict();
  end
endmodule : tb_pta_tracker
